// ==== tb/dscp_control_chk.sv ====
`timescale 1ns/1ps
module dscp_control_chk
   import dscp_pkg::*;
#(
   parameter int GAIN_BITS = 14
) (
   // clock, reset and pins
   input wire logic                   i_clk,
   input wire logic                   i_nrst,
   input wire logic                   i_ce,
   input wire logic                   i_ctl_load_strobe,
   input wire logic                   i_mute_pin,
   input wire logic                   i_emphasis_select_pin,
   input wire logic                   i_port_format_sel0,
   input wire logic                   i_port_format_sel1,
   input wire logic                   i_rate2x_pin,
   input wire logic                   i_rate4x_pin,
   // resolved settings
   input wire logic [GAIN_BITS-1:0]   o_gain_left,
   input wire dscp_pkg::dscp_fmt_type o_port_format,
   input wire logic [1:0]             o_emphasis_curve,
   input wire logic [1:0]             o_word_length_sel,
   input wire logic                   o_rate2x,
   input wire logic                   o_rate4x,
   input wire logic                   o_muted,
   input wire logic                   o_midscale,
   input wire logic                   o_running
);
   logic [9:0] up_q;
   always_ff @(posedge i_clk) up_q <= o_gain_left[GAIN_BITS-1 -: 10];
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_released;
      $rose(i_nrst);
   endsequence
   sequence s_resume;
      !o_running [*5] ##[1:6] o_running;
   endsequence
   a_reset_defaults: assert property (
      s_released |-> o_midscale && !o_running && o_gain_left == '0 && o_port_format == DSCP_FMT_RJ)
      else $error("outputs not at defaults after reset");
   a_resume_delay: assert property (s_released |-> s_resume)
      else $error("resume delay wrong");
   a_strobe_commits: assert property (
      !i_ctl_load_strobe [*8] |-> $stable(o_word_length_sel))
      else $error("setting changed without a load strobe");
   a_emph_pin: assert property (i_emphasis_select_pin [*5] |-> o_emphasis_curve == 2'h1)
      else $error("emphasis pin not honoured");
   a_fmt_pins: assert property (
      (i_port_format_sel0 && i_port_format_sel1) [*5] |-> o_port_format == DSCP_FMT_DSP)
      else $error("format pins not ORed in");
   a_rate_pins: assert property (
      (i_rate2x_pin && i_rate4x_pin) [*5] |-> o_rate2x && o_rate4x)
      else $error("rate pins not ORed in");
   a_mute_pin: assert property ((i_mute_pin && i_ce) [*5] |-> o_muted)
      else $error("mute pin not honoured");
   a_gain_step: assert property (
      o_running && $past(o_running) |-> o_gain_left == '0 ||
      (o_gain_left[GAIN_BITS-1 -: 10] - up_q) inside {10'h000, 10'h001, 10'h3ff})
      else $error("gain jumped by more than one step");
endmodule : dscp_control_chk

// ==== tb/dscp_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// host side of the serial control link
// ----------------------------------------
module dscp_host_model (
   // serial control pins
   output logic o_sck,
   output logic o_sdi,
   output logic o_latch
);
   initial begin
      o_sck   = 1'b0;
      o_sdi   = 1'b0;
      o_latch = 1'b0;
   end
   // shift clock stands still between frames, 48 ns period
   task automatic send(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         o_sdi = w[i];
         #24 o_sck = 1'b1;
         #24 o_sck = 1'b0;
      end
      o_latch = 1'b1;
      #24 o_latch = 1'b0;
      o_sdi = ~o_sdi;
   endtask : send
endmodule : dscp_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "dscp_consts.svh"
`define CHK(n, e, a) n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", n, e, a); end
module testbench;
   import dscp_pkg::*;
   // ----------------------------------------
   // stimulus, observed outputs
   // ----------------------------------------
   logic         i_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_frame_clk = 1'b0;
   logic         i_mute_pin = 1'b0, i_emphasis_select_pin = 1'b0;
   logic         i_port_format_sel0 = 1'b0, i_port_format_sel1 = 1'b0;
   logic         i_rate2x_pin = 1'b0, i_rate4x_pin = 1'b0;
   logic         i_ctl_shift_clock, i_ctl_serial_in, i_ctl_load_strobe;
   logic [1:0]   fcnt = 2'h0, o_emphasis_curve, o_word_length_sel;
   logic [13:0]  o_gain_left, o_gain_right;
   dscp_fmt_type o_port_format;
   logic         o_rate2x, o_rate4x, o_muted, o_midscale, o_running;
   int           error_cnt = 0, n_compared = 0;
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      fcnt <= fcnt + 2'h1;
      if (fcnt == 2'h3) i_frame_clk <= ~i_frame_clk;
   end
   dscp_host_model u_host (.o_sck(i_ctl_shift_clock), .o_sdi(i_ctl_serial_in),
      .o_latch(i_ctl_load_strobe));
   dscp_control #(.GROUP_DELAY_CYCLES(2), .GAIN_BITS(14)) u_dut (.i_clk, .i_nrst, .i_ce,
      .i_ctl_shift_clock, .i_ctl_serial_in, .i_ctl_load_strobe, .i_mute_pin,
      .i_emphasis_select_pin, .i_port_format_sel0, .i_port_format_sel1, .i_rate2x_pin,
      .i_rate4x_pin, .i_frame_clk, .o_gain_left, .o_gain_right, .o_port_format,
      .o_emphasis_curve, .o_word_length_sel, .o_rate2x, .o_rate4x, .o_muted, .o_midscale,
      .o_running);
   task automatic end_of_test;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [13:0] v, input logic [1:0] a);
      u_host.send({v, a});
      tick(10);
   endtask : wr
   // mute goes up before the format pins move and comes down after them
   task automatic pins(input logic p);
      @(posedge i_clk);
      if (p) i_mute_pin <= 1'b1;
      @(posedge i_clk);
      {i_emphasis_select_pin, i_port_format_sel0, i_port_format_sel1} <= {3{p}};
      {i_rate2x_pin, i_rate4x_pin} <= {2{p}};
      @(posedge i_clk);
      i_mute_pin <= p;
      tick(8);
   endtask : pins
   task automatic t_freeze;
      @(posedge i_clk);
      i_ce       <= 1'b0;
      i_mute_pin <= 1'b1;
      tick(8);
      `CHK("frozen_muted", 1'b0, o_muted)
      `CHK("frozen_running", 1'b1, o_running)
      @(posedge i_clk);
      i_mute_pin <= 1'b0;
      i_ce       <= 1'b1;
      tick(8);
      `CHK("muted", 1'b0, o_muted)
   endtask : t_freeze
   task automatic t_reset(input int hold);
      @(posedge i_clk);
      i_nrst <= 1'b0;
      repeat (hold) @(posedge i_clk);
      i_nrst <= 1'b1;
      tick(3);
      `CHK("midscale", 1'b1, o_midscale)
      `CHK("gain_left", 14'h0000, o_gain_left)
      `CHK("format", DSCP_FMT_RJ, o_port_format)
      `CHK("word_len", 2'h0, o_word_length_sel)
      tick(20);
      `CHK("running", 1'b1, o_running)
   endtask : t_reset
   task automatic t_ctrl;
      logic [13:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {4'h0, i[1:0], (i == 3) ? 2'h0 : i[1:0], 2'h0, i[1:0], i[1:0]};
         wr(v, `DSCP_ADDR_CTRL);
         `CHK("emphasis", i[1:0], o_emphasis_curve)
         `CHK("format", i[1:0], o_port_format)
         `CHK("word_len", v[7:6], o_word_length_sel)
         `CHK("rates", i[1:0], {o_rate2x, o_rate4x})
      end
      wr(14'h3fff, `DSCP_ADDR_NONE);
      `CHK("format", DSCP_FMT_DSP, o_port_format)
      `CHK("muted", 1'b0, o_muted)
      `CHK("running", 1'b1, o_running)
      wr(14'h0000, `DSCP_ADDR_CTRL);
   endtask : t_ctrl
   task automatic t_pins;
      pins(1'b1);
      `CHK("emphasis", 2'h1, o_emphasis_curve)
      `CHK("format", DSCP_FMT_DSP, o_port_format)
      `CHK("rates", 2'h3, {o_rate2x, o_rate4x})
      `CHK("muted", 1'b1, o_muted)
      pins(1'b0);
      `CHK("format", DSCP_FMT_RJ, o_port_format)
      `CHK("muted", 1'b0, o_muted)
   endtask : t_pins
   task automatic t_volume;
      wr(14'h0025, `DSCP_ADDR_LEFT);
      tick(1000);
      `CHK("gain_left", 14'h0025, o_gain_left)
      `CHK("gain_right_lo", 4'hf, o_gain_right[3:0])
      `CHK("right_ramping", 1'b1, o_gain_right != 14'h3fff)
      wr(14'h0010, `DSCP_ADDR_CTRL);
      tick(400);
      `CHK("muted", 1'b1, o_muted)
      `CHK("gain_left", 14'h0000, o_gain_left)
      wr(14'h0000, `DSCP_ADDR_CTRL);
      tick(400);
      `CHK("gain_left", 14'h0025, o_gain_left)
   endtask : t_volume
   task automatic t_soft;
      wr(14'h0020, `DSCP_ADDR_CTRL);
      `CHK("midscale", 1'b1, o_midscale)
      `CHK("running", 1'b0, o_running)
      wr(14'h0000, `DSCP_ADDR_CTRL);
      tick(400);
      `CHK("running", 1'b1, o_running)
      `CHK("gain_left", 14'h0025, o_gain_left)
   endtask : t_soft
   initial begin
      t_reset(10);
      t_ctrl;
      t_pins;
      t_freeze;
      t_volume;
      t_soft;
      t_reset(64);
      tick(400);
      `CHK("gain_left_lo", 4'hf, o_gain_left[3:0])
      end_of_test;
   end
   initial begin
      #300_000;
      error_cnt++;
      end_of_test;
   end
endmodule : testbench
bind dscp_control dscp_control_chk #(.GAIN_BITS(GAIN_BITS)) u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_ctl_load_strobe(i_ctl_load_strobe),
   .i_mute_pin(i_mute_pin), .i_emphasis_select_pin(i_emphasis_select_pin),
   .i_port_format_sel0(i_port_format_sel0), .i_port_format_sel1(i_port_format_sel1),
   .i_rate2x_pin(i_rate2x_pin), .i_rate4x_pin(i_rate4x_pin), .o_gain_left(o_gain_left),
   .o_port_format(o_port_format), .o_emphasis_curve(o_emphasis_curve),
   .o_word_length_sel(o_word_length_sel), .o_rate2x(o_rate2x), .o_rate4x(o_rate4x),
   .o_muted(o_muted), .o_midscale(o_midscale), .o_running(o_running));

// ==== verilog/dscp_consts.svh ====
`ifndef DSCP_CONSTS_SVH
`define DSCP_CONSTS_SVH
// ------------------------------------------------------------
// word layout
// ------------------------------------------------------------
`define DSCP_WORD_BITS     16
`define DSCP_DATA_BITS     14
`define DSCP_ADDR_LEFT     2'h0
`define DSCP_ADDR_CTRL     2'h1
`define DSCP_ADDR_RIGHT    2'h2
`define DSCP_ADDR_NONE     2'h3
// ------------------------------------------------------------
// control register fields (bit positions within the 14-bit value)
// ------------------------------------------------------------
`define DSCP_CTL_EMPHASIS_SELECT_PIN_LO  0
`define DSCP_CTL_FMT_LO    2
`define DSCP_CTL_MUTE      4
`define DSCP_CTL_SRST      5
`define DSCP_CTL_WLEN_LO   6
`define DSCP_CTL_INT4      8
`define DSCP_CTL_INT2      9
// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define DSCP_CTL_RESET     14'h0000
`define DSCP_VOL_RESET     14'h3fff
`define DSCP_EMPHASIS_SELECT_PIN_441     2'h1
`define DSCP_RESUME_EXTRA  3
`define DSCP_CLK_PERIOD_NS 10
`endif

// ==== verilog/dscp_control.sv ====
`timescale 1ns/1ps
`include "dscp_consts.svh"
// Functional notes
// - sample serial input on shift clock rise
// - load strobe rise commits word to register
// - free-running shift clock commits nothing alone
// - latched values cross safely into core domain
// - attenuation updates at next frame edge
// - mute pin or bit 4 mutes both
// - mute ramps gain, unmute restores volume
// - address 01 loads control register
// - emphasis pin forces 44.1 kHz curve
// - bits 1:0 select emphasis curve
// - format is bits 3:2 or pins
// - bits 7:6 select justified word length
// - bits 9,8 ORed with rate pins
// - reset forces outputs to midscale
// - resume after group delay plus three
// - hardware reset loads all defaults
// - bit 5 holds internal defaults while set
// - soft reset keeps serial registers
// - format pins switch without reset
// - sixteen bits, msb first, low two address
// - address 00 left, 10 right
// - upper ten bits step per sample
module dscp_control #(
   parameter int GROUP_DELAY_CYCLES = 40,
   parameter int GAIN_BITS          = 14
) (
   // core clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic                  i_ce,
   // serial control link
   input  wire logic                  i_ctl_shift_clock,
   input  wire logic                  i_ctl_serial_in,
   input  wire logic                  i_ctl_load_strobe,
   // configuration pins
   input  wire logic                  i_mute_pin,
   input  wire logic                  i_emphasis_select_pin,
   input  wire logic                  i_port_format_sel0,
   input  wire logic                  i_port_format_sel1,
   input  wire logic                  i_rate2x_pin,
   input  wire logic                  i_rate4x_pin,
   // audio frame clock
   input  wire logic                  i_frame_clk,
   // resolved settings
   output logic [GAIN_BITS-1:0]       o_gain_left,
   output logic [GAIN_BITS-1:0]       o_gain_right,
   output dscp_pkg::dscp_fmt_type     o_port_format,
   output logic [1:0]                 o_emphasis_curve,
   output logic [1:0]                 o_word_length_sel,
   output logic                       o_rate2x,
   output logic                       o_rate4x,
   output logic                       o_muted,
   output logic                       o_midscale,
   output logic                       o_running
);
   import dscp_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (GAIN_BITS != `DSCP_DATA_BITS) begin : g_bad_gain
      $error("GAIN_BITS must equal the register data width");
   end
   if (GROUP_DELAY_CYCLES < 1 || GROUP_DELAY_CYCLES > 65000) begin : g_bad_delay
      $error("GROUP_DELAY_CYCLES out of range");
   end

   localparam int RESUME_CYCLES = GROUP_DELAY_CYCLES + `DSCP_RESUME_EXTRA;
   localparam int WB = `DSCP_WORD_BITS;
   localparam int DB = `DSCP_DATA_BITS;

   // ------------------------------------------------------------
   // link domain: shift register and committed word
   // ------------------------------------------------------------
   logic [WB-1:0] shift_q;
   logic [WB-1:0] link_word_q;
   logic          link_tgl_q;

   always_ff @(posedge i_ctl_shift_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_q <= '0;
      end else begin
         shift_q <= {shift_q[WB-2:0], i_ctl_serial_in};
      end
   end

   // strobe edge commits the word; toggle signals the core domain
   always_ff @(posedge i_ctl_load_strobe or negedge i_nrst) begin
      if (!i_nrst) begin
         link_word_q <= '0;
         link_tgl_q  <= 1'b0;
      end else begin
         link_word_q <= shift_q;
         link_tgl_q  <= ~link_tgl_q;
      end
   end

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic             tgl_seen_q;

   assign async_in = {link_tgl_q, i_frame_clk, i_mute_pin, i_emphasis_select_pin,
                      i_port_format_sel1, i_port_format_sel0, i_rate2x_pin,
                      i_rate4x_pin, 1'b0};

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (i_ce) begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   logic s_tgl;
   logic s_frame;
   logic s_mute;
   logic s_emph;
   logic [1:0] s_fmt;
   logic s_r2;
   logic s_r4;
   assign s_tgl   = sync2_q[8];
   assign s_frame = sync2_q[7];
   assign s_mute  = sync2_q[6];
   assign s_emph  = sync2_q[5];
   assign s_fmt   = sync2_q[4:3];
   assign s_r2    = sync2_q[2];
   assign s_r4    = sync2_q[1];

   logic frame_q;
   logic frame_edge;
   logic word_new;
   assign word_new   = s_tgl != tgl_seen_q;
   assign frame_edge = s_frame != frame_q;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tgl_seen_q <= 1'b0;
         frame_q    <= 1'b0;
      end else if (i_ce) begin
         tgl_seen_q <= s_tgl;
         frame_q    <= s_frame;
      end
   end

   // ------------------------------------------------------------
   // register file (word stable once toggle is seen synchronised)
   // ------------------------------------------------------------
   logic [DB-1:0] ctl_q;
   logic [DB-1:0] vol_l_q;
   logic [DB-1:0] vol_r_q;
   logic [1:0]    waddr;
   logic [DB-1:0] wdata;
   assign waddr = link_word_q[1:0];
   assign wdata = link_word_q[WB-1:2];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctl_q   <= `DSCP_CTL_RESET;
         vol_l_q <= `DSCP_VOL_RESET;
         vol_r_q <= `DSCP_VOL_RESET;
      end else if (i_ce && word_new) begin
         case (waddr)
            `DSCP_ADDR_CTRL:  ctl_q   <= wdata;
            `DSCP_ADDR_LEFT:  vol_l_q <= wdata;
            `DSCP_ADDR_RIGHT: vol_r_q <= wdata;
            default: ;
         endcase
      end
   end

   logic soft_rst;
   assign soft_rst = ctl_q[`DSCP_CTL_SRST];

   // ------------------------------------------------------------
   // reset / resume sequencer
   // ------------------------------------------------------------
   dscp_state_type st_q;
   logic [16:0]    rcnt_q;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q   <= DSCP_ST_RESET;
         rcnt_q <= '0;
      end else if (i_ce) begin
         case (st_q)
            DSCP_ST_RESET: begin
               rcnt_q <= '0;
               if (!soft_rst) begin
                  st_q <= DSCP_ST_RESUME;
               end
            end
            DSCP_ST_RESUME: begin
               if (soft_rst) begin
                  st_q <= DSCP_ST_RESET;
               end else if (rcnt_q == 17'(RESUME_CYCLES - 1)) begin
                  st_q <= DSCP_ST_RUN;
               end else begin
                  rcnt_q <= rcnt_q + 17'h0_0001;
               end
            end
            DSCP_ST_RUN: begin
               if (soft_rst) begin
                  st_q <= DSCP_ST_RESET;
               end
            end
            default: st_q <= DSCP_ST_RESET;
         endcase
      end
   end

   logic running;
   assign running = st_q == DSCP_ST_RUN;

   // ------------------------------------------------------------
   // volume targets taken at frame edges, ramping gain
   // ------------------------------------------------------------
   logic          muted;
   logic [DB-1:0] tgt_l_q;
   logic [DB-1:0] tgt_r_q;
   logic [DB-1:0] gain_l_q;
   logic [DB-1:0] gain_r_q;
   assign muted = s_mute | ctl_q[`DSCP_CTL_MUTE];

   function automatic logic [DB-1:0] ramp_step(input logic [DB-1:0] g,
                                               input logic [DB-1:0] t);
      logic [9:0] hi;
      hi = g[DB-1:4];
      if (hi < t[DB-1:4]) begin
         hi = hi + 10'h001;
      end else if (hi > t[DB-1:4]) begin
         hi = hi - 10'h001;
      end
      ramp_step = {hi, t[3:0]};
   endfunction : ramp_step

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tgt_l_q  <= '0;
         tgt_r_q  <= '0;
         gain_l_q <= '0;
         gain_r_q <= '0;
      end else if (i_ce) begin
         if (!running) begin
            tgt_l_q  <= '0;
            tgt_r_q  <= '0;
            gain_l_q <= '0;
            gain_r_q <= '0;
         end else if (frame_edge) begin
            tgt_l_q  <= muted ? '0 : vol_l_q;
            tgt_r_q  <= muted ? '0 : vol_r_q;
            gain_l_q <= ramp_step(gain_l_q, tgt_l_q);
            gain_r_q <= ramp_step(gain_r_q, tgt_r_q);
         end
      end
   end

   // ------------------------------------------------------------
   // resolved outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_gain_left       <= '0;
         o_gain_right      <= '0;
         o_port_format     <= DSCP_FMT_RJ;
         o_emphasis_curve  <= 2'h0;
         o_word_length_sel <= 2'h0;
         o_rate2x          <= 1'b0;
         o_rate4x          <= 1'b0;
         o_muted           <= 1'b0;
         o_midscale        <= 1'b1;
         o_running         <= 1'b0;
      end else if (i_ce) begin
         o_gain_left       <= gain_l_q;
         o_gain_right      <= gain_r_q;
         o_port_format     <= dscp_fmt_type'(ctl_q[`DSCP_CTL_FMT_LO +: 2] | s_fmt);
         o_emphasis_curve  <= s_emph ? `DSCP_EMPHASIS_SELECT_PIN_441
                                     : ctl_q[`DSCP_CTL_EMPHASIS_SELECT_PIN_LO +: 2];
         o_word_length_sel <= ctl_q[`DSCP_CTL_WLEN_LO +: 2];
         o_rate2x          <= ctl_q[`DSCP_CTL_INT2] | s_r2;
         o_rate4x          <= ctl_q[`DSCP_CTL_INT4] | s_r4;
         o_muted           <= muted;
         o_midscale        <= !running;
         o_running         <= running;
      end
   end

endmodule : dscp_control

// ==== verilog/dscp_pkg.sv ====
package dscp_pkg;
   typedef enum logic [1:0] {
      DSCP_FMT_RJ  = 2'h0,
      DSCP_FMT_I2S = 2'h1,
      DSCP_FMT_LJ  = 2'h2,
      DSCP_FMT_DSP = 2'h3
   } dscp_fmt_type;
   typedef enum logic [2:0] {
      DSCP_ST_RESET  = 3'b001,
      DSCP_ST_RESUME = 3'b010,
      DSCP_ST_RUN    = 3'b100
   } dscp_state_type;
endpackage : dscp_pkg
